// file: uart_trig_pkg.sv
// Register map, field layout, reset values and mode encodings of the serial trigger decoder.
package uart_trig_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_TOUT = 8'h08;
  localparam logic [7:0] OFS_EWORD = 8'h0c;
  localparam logic [7:0] OFS_PAT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RIDX = 8'h18;
  localparam logic [7:0] OFS_RSTART = 8'h1c;
  localparam logic [7:0] OFS_RSTOP = 8'h20;
  localparam logic [7:0] OFS_RINFO = 8'h24;
  localparam logic [7:0] OFS_RRATE = 8'h28;
  localparam int C_MODE = 0;
  localparam int C_SRC = 3;
  localparam int C_PAR = 4;
  localparam int C_POL = 7;
  localparam int C_MSB = 8;
  localparam int C_STOP = 9;
  localparam int C_DBITS = 11;
  localparam int C_PKT = 15;
  localparam int C_OP = 17;
  localparam int C_PLEN = 20;
  localparam int C_POS = 22;
  localparam int C_CAP = 26;
  localparam int I_LINE = 9;
  localparam int I_INC = 10;
  localparam int I_SERR = 11;
  localparam int I_SPERR = 12;
  localparam int I_PERR = 13;
  localparam int I_ERR = 14;
  localparam int I_OK = 15;
  localparam logic [31:0] CTRL_RST = 32'h0400_4000;
  localparam logic [31:0] BAUD_RST = 32'h0000_00d9;
  localparam logic [31:0] TOUT_RST = 32'h0000_ffff;
  localparam logic [8:0] EWORD_RST = 9'h00a;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;
  typedef enum logic [2:0] {TRG_START, TRG_PKT, TRG_DATA, TRG_PAR, TRG_BRK, TRG_STOP} trig_e;
  typedef enum logic [2:0] {PAR_NONE, PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE, PAR_DC} par_e;
  typedef enum logic [1:0] {PKT_NONE, PKT_END, PKT_TOUT} pkt_e;
  typedef enum logic [2:0] {OP_EQ, OP_NE, OP_LT, OP_LE, OP_GT, OP_GE} op_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_TAIL, RX_BRK} rx_e;
endpackage : uart_trig_pkg

// file: uart_line_rx.sv
// Word framer for one monitored serial line.
`timescale 1ns/1ns
`default_nettype none
module uart_line_rx
  import uart_trig_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial pin, asynchronous to aclk
  input wire logic line,
  // Line configuration
  input wire logic en,
  input wire logic pol_low,
  input wire logic msb_first,
  input wire logic [3:0] dbits,
  input wire par_e pmode,
  input wire logic [1:0] stop_sel,
  input wire logic [BAUD_W-1:0] baud,
  // Word events
  output logic start_p,
  output logic done_p,
  output logic inc,
  output logic serr,
  output logic sperr,
  output logic perr,
  output logic brk_p,
  output logic [8:0] value
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    rx_e st;
    logic [BAUD_W-1:0] cnt;
    logic [3:0] nbit;
    logic [8:0] sh;
    logic ones;
    logic seen1;
    logic pe;
    logic start_p;
    logic done_p;
    logic inc;
    logic serr;
    logic sperr;
    logic perr;
    logic brk_p;
    logic [8:0] value;
  } rx_s;
  rx_s q;
  rx_s d;
  logic lv;
  logic lv_p;
  logic tick;
  logic has_par;
  logic [3:0] nb;
  logic [BAUD_W-1:0] half;
  logic [BAUD_W-1:0] tail;
  assign lv = q.s2 ^ pol_low; // [RULE17]
  assign lv_p = q.s3 ^ pol_low;
  assign tick = q.cnt == '0;
  assign has_par = pmode != PAR_NONE;
  assign nb = (dbits < 4'd5) ? 4'd5 : (has_par && dbits > 4'd8) ? 4'd8 : dbits; // [RULE18]
  assign half = baud >> 1;
  assign tail = (stop_sel == 2'd0) ? half : (stop_sel == 2'd1) ? baud : baud + half; // [RULE18]
  always_comb begin
    d = q;
    d.s1 = line;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.start_p = 1'b0;
    d.done_p = 1'b0;
    d.brk_p = 1'b0;
    if (!tick) begin
      d.cnt = q.cnt - BAUD_W'(1);
    end
    case (q.st)
      RX_IDLE: begin
        // Only a falling edge after a finished stop period starts a word.
        if (en && lv_p && !lv) begin // [RULE1]
          d.st = RX_START;
          d.cnt = half; // [RULE21]
          d.start_p = 1'b1;
          d.seen1 = 1'b0;
          d.ones = 1'b0;
          d.nbit = 4'h0;
          d.pe = 1'b0;
          d.sh = '0;
        end
      end
      RX_START: begin
        if (tick) begin
          d.cnt = baud - BAUD_W'(1);
          d.st = RX_DATA;
          if (lv) begin // [RULE15]
            d.st = RX_IDLE;
            d.done_p = 1'b1;
            d.inc = 1'b0;
            d.serr = 1'b1;
            d.sperr = 1'b0;
            d.perr = 1'b0;
            d.value = '0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          d.cnt = baud - BAUD_W'(1);
          d.sh = msb_first ? {q.sh[7:0], lv} : {lv, q.sh[8:1]};
          d.ones = q.ones ^ lv;
          d.seen1 = q.seen1 | lv;
          d.nbit = q.nbit + 4'h1;
          if (q.nbit == nb - 4'h1) begin
            d.st = has_par ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          d.cnt = baud - BAUD_W'(1);
          d.seen1 = q.seen1 | lv;
          d.st = RX_STOP;
          d.pe = (pmode == PAR_ODD && lv == q.ones) || (pmode == PAR_EVEN && lv != q.ones) ||
                 (pmode == PAR_MARK && !lv) || (pmode == PAR_SPACE && lv); // [RULE20]
        end
      end
      RX_STOP: begin
        if (tick) begin
          d.done_p = 1'b1;
          d.inc = 1'b0;
          d.serr = 1'b0;
          d.sperr = !lv; // [RULE7]
          d.perr = q.pe; // [RULE15]
          d.value = msb_first ? (q.sh & (9'h1ff >> (4'd9 - nb))) : (q.sh >> (4'd9 - nb));
          if (lv) begin
            d.st = RX_TAIL;
            d.cnt = tail;
          end else if (!q.seen1) begin
            // A word of zeros with a low stop bit means the line is held in break.
            d.st = RX_BRK;
            d.brk_p = 1'b1; // [RULE6]
          end else begin
            d.st = RX_IDLE;
          end
        end
      end
      RX_TAIL: begin
        if (tick) begin
          d.st = RX_IDLE;
        end
      end
      RX_BRK: begin
        if (lv) begin
          d.st = RX_IDLE;
        end
      end
      default: begin
        d.st = RX_IDLE;
      end
    endcase
    if (!en && q.st inside {RX_START, RX_DATA, RX_PAR, RX_STOP}) begin // [RULE14]
      d.st = RX_IDLE;
      d.done_p = 1'b1;
      d.inc = 1'b1;
      d.serr = 1'b0;
      d.sperr = 1'b0;
      d.perr = 1'b0;
      d.brk_p = 1'b0;
      d.value = q.sh;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign start_p = q.start_p;
  assign done_p = q.done_p;
  assign inc = q.inc;
  assign serr = q.serr;
  assign sperr = q.sperr;
  assign perr = q.perr;
  assign brk_p = q.brk_p;
  assign value = q.value;
endmodule : uart_line_rx
`default_nettype wire

// file: uart_trigger_decoder.sv
// Serial line trigger and word decoder with an AXI4-Lite register port.
// Summary of operation
// [RULE1] Start-bit mode fires on first low bit after a finished stop bit.
// [RULE2] Packet-start mode fires at the start of each detected packet.
// [RULE3] Data mode fires when pattern matches at set word position, chosen operator.
// [RULE4] A multi-word pattern must match on consecutive words before firing.
// [RULE5] Parity trigger only with a parity mode set; fires on wrong parity bit.
// [RULE6] Break is signalled when the line stays low over a whole word.
// [RULE7] Stop-error mode fires when the sampled stop bit is low.
// [RULE8] All triggers look at one line, chosen as transmit or receive.
// [RULE9] Pattern words are most significant bit first regardless of bit order.
// [RULE10] A set number of words after packet start is skipped before matching.
// [RULE11] Word position counts only when packet detection is on.
// [RULE12] Every decoded word gets the next sequential index.
// [RULE13] Each word records start bit and stop bit timestamps.
// [RULE14] Words cut short by capture end are incomplete, never valid.
// [RULE15] Start, stop and parity errors are flagged apart, plus an any-error flag.
// [RULE16] Each word reports its value, its line and its data rate.
// [RULE17] Start bit is 0, stop and idle are 1; polarity picks the levels.
// [RULE18] Five to eight data bits, nine without parity, then 1, 1.5 or 2 stops; without parity, settings above nine are used unclamped.
// [RULE19] Packets end on an end word or idle timeout; next start opens one.
// [RULE20] Parity odd, even, mark, space or don't care, checked as configured.
// [RULE21] Bits are sampled mid-period, counted from the start bit falling edge.
`timescale 1ns/1ns
`default_nettype none
module uart_trigger_decoder
  import uart_trig_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Monitored serial lines
  input wire logic tx_line,
  input wire logic rx_line,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Events
  output logic trig,
  output logic rec_stb
);
  if (BAUD_W < 4 || BAUD_W > 32) begin : g_chk
    $error("BAUD_W must lie between 4 and 32.");
  end
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [BAUD_W-1:0] baud;
    logic [31:0] tout;
    logic [8:0] eword;
    logic [31:0] pat;
    logic [31:0] ts;
    logic trig;
    logic [15:0] trig_cnt;
    logic rec_stb;
    logic rec_vld;
    logic [15:0] rec_idx;
    logic [31:0] rec_start;
    logic [31:0] rec_stop;
    logic [15:0] rec_info;
    logic [BAUD_W-1:0] rec_rate;
    logic [1:0][31:0] tstart;
    logic pkt_new;
    logic idle_on;
    logic [31:0] idle_cnt;
    logic [4:0] wpos;
    logic [1:0] mcnt;
  } st_s;
  st_s q;
  st_s d;
  logic [1:0] lines;
  logic [1:0] start_p;
  logic [1:0] done_p;
  logic [1:0] inc;
  logic [1:0] serr;
  logic [1:0] sperr;
  logic [1:0] perr;
  logic [1:0] brk_p;
  logic [1:0][8:0] val;
  trig_e mode;
  par_e pmode;
  pkt_e pkt;
  op_e op;
  logic sel;
  logic [1:0] plen;
  logic [3:0] pos;
  logic s_start;
  logic s_done;
  logic s_inc;
  logic s_sperr;
  logic s_perr;
  logic s_brk;
  logic [8:0] s_val;
  logic [7:0] pw;
  logic at_pos;
  logic hit;
  logic dfire;
  logic pkt_go;
  logic par_on;
  logic fire;
  assign lines = {rx_line, tx_line};
  assign mode = trig_e'(q.ctrl[C_MODE +: 3]);
  assign pmode = par_e'(q.ctrl[C_PAR +: 3]);
  assign pkt = pkt_e'(q.ctrl[C_PKT +: 2]);
  assign op = op_e'(q.ctrl[C_OP +: 3]);
  assign sel = q.ctrl[C_SRC];
  assign plen = q.ctrl[C_PLEN +: 2];
  assign pos = q.ctrl[C_POS +: 4];
  for (genvar i = 0; i < 2; i++) begin : g_line
    uart_line_rx #(
      .BAUD_W(BAUD_W)
    ) u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .line(lines[i]),
      .en(q.ctrl[C_CAP]),
      .pol_low(q.ctrl[C_POL]),
      .msb_first(q.ctrl[C_MSB]),
      .dbits(q.ctrl[C_DBITS +: 4]),
      .pmode(pmode),
      .stop_sel(q.ctrl[C_STOP +: 2]),
      .baud(q.baud),
      .start_p(start_p[i]),
      .done_p(done_p[i]),
      .inc(inc[i]),
      .serr(serr[i]),
      .sperr(sperr[i]),
      .perr(perr[i]),
      .brk_p(brk_p[i]),
      .value(val[i])
    );
  end
  // Every trigger condition is taken from the selected line only.
  assign s_start = start_p[sel]; // [RULE8]
  assign s_done = done_p[sel];
  assign s_inc = inc[sel];
  assign s_sperr = sperr[sel];
  assign s_perr = perr[sel];
  assign s_brk = brk_p[sel];
  assign s_val = val[sel];
  // Pattern word k sits k bytes below the top, so the first word is the most significant.
  assign pw = q.pat[{~q.mcnt, 3'b000} +: 8]; // [RULE9]
  assign at_pos = (pkt == PKT_NONE) || (q.mcnt != 2'd0) || (q.wpos == {1'b0, pos}); // [RULE10] [RULE11]
  assign hit = s_done && !s_inc && cmp_word(s_val[7:0], pw, op) && at_pos; // [RULE3]
  assign dfire = hit && (q.mcnt == plen); // [RULE4]
  assign pkt_go = s_start && q.pkt_new && (pkt != PKT_NONE); // [RULE2]
  assign par_on = pmode inside {PAR_ODD, PAR_EVEN, PAR_MARK, PAR_SPACE};
  assign fire = (mode == TRG_START && s_start) || (mode == TRG_PKT && pkt_go) || // [RULE1]
                (mode == TRG_DATA && dfire) ||
                (mode == TRG_PAR && par_on && s_done && s_perr) || // [RULE5]
                (mode == TRG_BRK && s_brk) || // [RULE6]
                (mode == TRG_STOP && s_done && s_sperr && !s_inc); // [RULE7]
  function automatic logic cmp_word(input logic [7:0] a, input logic [7:0] b, input op_e o);
    case (o)
      OP_EQ: return a == b;
      OP_NE: return a != b;
      OP_LT: return a < b;
      OP_LE: return a <= b;
      OP_GT: return a > b;
      OP_GE: return a >= b;
      default: return 1'b0;
    endcase
  endfunction : cmp_word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge
  always_comb begin
    d = q;
    d.ts = q.ts + 32'h1;
    d.trig = fire;
    d.rec_stb = 1'b0;
    if (fire) begin
      d.trig_cnt = q.trig_cnt + 16'h1;
    end
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (bready && q.bvalid) begin
      d.bvalid = 1'b0;
    end
    // A write lands only once both halves are held, so their arrival order does not matter.
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OK;
      case (q.awaddr)
        OFS_CTRL: d.ctrl = merge(q.ctrl, q.wdata, q.wstrb);
        OFS_BAUD: d.baud = BAUD_W'(merge(32'(q.baud), q.wdata, q.wstrb));
        OFS_TOUT: d.tout = merge(q.tout, q.wdata, q.wstrb);
        OFS_EWORD: d.eword = 9'(merge(32'(q.eword), q.wdata, q.wstrb));
        OFS_PAT: d.pat = merge(q.pat, q.wdata, q.wstrb);
        default: d.bresp = RESP_SLV;
      endcase
    end
    if (rready && q.rvalid) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OK;
      case (araddr)
        OFS_CTRL: d.rdata = q.ctrl;
        OFS_BAUD: d.rdata = 32'(q.baud);
        OFS_TOUT: d.rdata = q.tout;
        OFS_EWORD: d.rdata = 32'(q.eword);
        OFS_PAT: d.rdata = q.pat;
        OFS_STAT: d.rdata = {q.rec_vld, 15'h0, q.trig_cnt};
        OFS_RIDX: d.rdata = 32'(q.rec_idx);
        OFS_RSTART: d.rdata = q.rec_start;
        OFS_RSTOP: d.rdata = q.rec_stop;
        OFS_RINFO: d.rdata = 32'(q.rec_info);
        OFS_RRATE: d.rdata = 32'(q.rec_rate);
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLV;
        end
      endcase
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;
    // Packet framing on the selected line.
    if (s_start) begin
      d.idle_on = 1'b0;
      if (q.pkt_new) begin // [RULE19]
        d.pkt_new = 1'b0;
        d.wpos = 5'h0;
        d.mcnt = 2'd0;
      end
    end
    if (s_done && !s_inc) begin
      d.wpos = (q.wpos == 5'h1f) ? q.wpos : q.wpos + 5'h1;
      d.idle_on = 1'b1;
      d.idle_cnt = 32'h0;
      if (pkt == PKT_END && s_val == q.eword) begin // [RULE19]
        d.pkt_new = 1'b1;
      end
      // A mismatch drops a partial match; the word is not retried as the first one.
      d.mcnt = dfire ? 2'd0 : hit ? q.mcnt + 2'd1 : 2'd0; // [RULE4]
    end else if (q.idle_on) begin
      d.idle_cnt = q.idle_cnt + 32'h1;
      if (pkt == PKT_TOUT && q.idle_cnt >= q.tout) begin // [RULE19]
        d.pkt_new = 1'b1;
        d.idle_on = 1'b0;
      end
    end
    // Decode records for both lines; the receive line is recorded last when both finish.
    for (int i = 0; i < 2; i++) begin
      if (start_p[i]) begin
        d.tstart[i] = q.ts; // [RULE13]
      end
      if (done_p[i]) begin
        d.rec_idx = d.rec_idx + 16'h1; // [RULE12]
        d.rec_start = q.tstart[i]; // [RULE13]
        d.rec_stop = q.ts;
        d.rec_rate = q.baud; // [RULE16]
        d.rec_info = {!inc[i] && !(serr[i] || sperr[i] || perr[i]), // [RULE14]
                      serr[i] || sperr[i] || perr[i], perr[i], sperr[i], serr[i], // [RULE15]
                      inc[i], 1'(i), val[i]}; // [RULE16]
        d.rec_stb = 1'b1;
        d.rec_vld = 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.baud <= BAUD_W'(BAUD_RST);
      q.tout <= TOUT_RST;
      q.eword <= EWORD_RST;
      q.pat <= PAT_RST;
      q.pkt_new <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign trig = q.trig;
  assign rec_stb = q.rec_stb;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_start_trig: assert property (mode == TRG_START && s_start |=> trig) // [RULE1]
    else $error("Start bit did not trigger.");
  a_pkt_cause: assert property (trig && mode == TRG_PKT |-> $past(s_start) && $past(q.pkt_new)) // [RULE2]
    else $error("Packet trigger without a packet start.");
  a_data_fire: assert property (mode == TRG_DATA && dfire |=> trig) // [RULE3]
    else $error("Data match did not trigger.");
  a_data_seq: assert property (trig && mode == TRG_DATA |-> $past(q.mcnt) == $past(plen)) // [RULE4]
    else $error("Data trigger before the whole pattern matched.");
  a_par_gate: assert property (trig && mode == TRG_PAR |-> $past(par_on) && $past(s_perr)) // [RULE5]
    else $error("Parity trigger without parity mode or error.");
  a_brk_trig: assert property (mode == TRG_BRK && s_brk |=> trig) // [RULE6]
    else $error("Break did not trigger.");
  a_stop_trig: assert property (mode == TRG_STOP && s_done && s_sperr && !s_inc |=> trig ##1 !trig) // [RULE7]
    else $error("Stop error trigger missing or stretched.");
  a_src_only: assert property (mode == TRG_START && !s_start |=> !trig) // [RULE8]
    else $error("Trigger from the unselected line.");
  a_pos_skip: assert property (hit && q.mcnt == 2'd0 && pkt != PKT_NONE |-> q.wpos == {1'b0, pos}) // [RULE10]
    else $error("Pattern compare started at the wrong word.");
  a_idx_step: assert property (done_p == 2'b01 |=> q.rec_idx == $past(q.rec_idx) + 16'h1) // [RULE12]
    else $error("Word index did not advance by one.");
  a_stop_stamp: assert property (done_p == 2'b10 |=> q.rec_stop == $past(q.ts) && rec_stb) // [RULE13]
    else $error("Stop timestamp wrong.");
  a_inc_notok: assert property (q.rec_info[I_INC] |-> !q.rec_info[I_OK]) // [RULE14]
    else $error("Incomplete word reported valid.");
endmodule : uart_trigger_decoder
`default_nettype wire

// file: uart_tx_model.sv
// Behavioural serial transmitter that drives one monitored line.
`timescale 1ns/1ns
`default_nettype none
module uart_tx_model #(
  parameter int BIT = 8
) (
  // Clock
  input wire logic aclk,
  // Serial output
  output logic line
);
  // The line idles at logic 1 with idle-high polarity.
  initial line = 1'b1;

  task automatic hold(input logic v);
    line <= v;
    repeat (BIT) @(posedge aclk);
  endtask : hold

  // A negative parity argument sends no parity bit; sb is the stop bit level.
  task automatic send(input logic [7:0] d, input int pb, input logic sb);
    hold(1'b0);
    for (int i = 0; i < 8; i++) hold(d[i]);
    if (pb >= 0) hold(pb[0]);
    hold(sb);
    hold(1'b1);
  endtask : send
endmodule : uart_tx_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the serial trigger decoder.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import uart_trig_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire logic tx_line;
  wire logic rx_line;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, trig, rec_stb;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, ts0, ts1;
  int n_mismatch = 0;
  int checked = 0;
  int ntrig = 0;
  int nrec = 0;

  always #20 aclk = ~aclk;
  always @(posedge aclk) if (trig === 1'b1) ntrig++;
  always @(posedge aclk) if (rec_stb === 1'b1) nrec++;

  uart_trigger_decoder dut (
    .aclk(aclk), .aresetn(aresetn), .tx_line(tx_line), .rx_line(rx_line),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .trig(trig), .rec_stb(rec_stb)
  );
  uart_tx_model tx_m (.aclk(aclk), .line(tx_line));
  uart_tx_model rx_m (.aclk(aclk), .line(rx_line));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // Each task starts one edge late so no signal is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait; the slave's latency is not assumed here.
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk(d, exp, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask : rchk

  // Sends one word and compares the number of trigger pulses it caused.
  task automatic word(input logic rxl, input logic [7:0] d, input int pb, input logic sb,
                      input int et);
    int t0;
    int r0;
    t0 = ntrig;
    r0 = nrec;
    if (rxl) rx_m.send(d, pb, sb);
    else tx_m.send(d, pb, sb);
    repeat (6) @(posedge aclk);
    chk(ntrig - t0, et, "trigger count");
    chk(nrec - r0, 32'h1, "record count");
  endtask : word

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(OFS_CTRL, CTRL_RST, RESP_OK);
    rchk(OFS_BAUD, BAUD_RST, RESP_OK);
    rchk(OFS_TOUT, TOUT_RST, RESP_OK);
    rchk(8'h3c, 32'h0, RESP_SLV);
    wr(OFS_STAT, 32'h1, RESP_SLV);
    wr(OFS_BAUD, 32'h8, RESP_OK);
    wr(OFS_CTRL, CTRL_RST, RESP_OK);
    word(1'b0, 8'h33, -1, 1'b1, 1);
    rchk(OFS_RIDX, 32'h1, RESP_OK);
    rchk(OFS_RINFO, 32'h8033, RESP_OK);
    rchk(OFS_RRATE, 32'h8, RESP_OK);
    rdr(OFS_RSTART, ts0, rr);
    rdr(OFS_RSTOP, ts1, rr);
    chk({30'h0, rr}, {30'h0, RESP_OK}, "read response");
    chk(ts1 - ts0, 32'd77, "stop minus start time");
    wr(OFS_CTRL, CTRL_RST | 32'h8, RESP_OK);
    word(1'b0, 8'h55, -1, 1'b1, 0);
    word(1'b1, 8'h55, -1, 1'b1, 1);
    rchk(OFS_RIDX, 32'h3, RESP_OK);
    rchk(OFS_RINFO, 32'h8255, RESP_OK);
    wr(OFS_CTRL, CTRL_RST | 32'h5, RESP_OK);
    word(1'b0, 8'h0f, -1, 1'b0, 1);
    rchk(OFS_RINFO, 32'h500f, RESP_OK);
    wr(OFS_CTRL, CTRL_RST | 32'h23, RESP_OK);
    word(1'b0, 8'h03, 1, 1'b1, 1);
    rchk(OFS_RINFO, 32'h6003, RESP_OK);
    word(1'b0, 8'h03, 0, 1'b1, 0);
    wr(OFS_CTRL, CTRL_RST | 32'h13, RESP_OK);
    word(1'b0, 8'h03, 1, 1'b1, 0);
    wr(OFS_CTRL, CTRL_RST | 32'h3, RESP_OK);
    word(1'b0, 8'h03, -1, 1'b1, 0);
    wr(OFS_CTRL, CTRL_RST | 32'h4, RESP_OK);
    word(1'b0, 8'h00, -1, 1'b0, 1);
    wr(OFS_PAT, 32'h7200_0000, RESP_OK);
    wr(OFS_CTRL, CTRL_RST | 32'h2, RESP_OK);
    word(1'b0, 8'h72, -1, 1'b1, 1);
    word(1'b0, 8'h4e, -1, 1'b1, 0);
    wr(OFS_PAT, 32'h7233_0000, RESP_OK);
    wr(OFS_CTRL, CTRL_RST | 32'h0010_0002, RESP_OK);
    word(1'b0, 8'h72, -1, 1'b1, 0);
    word(1'b0, 8'h33, -1, 1'b1, 1);
    // End-word packets: only the first start after the end word opens a packet.
    wr(OFS_CTRL, CTRL_RST | 32'h0000_8001, RESP_OK);
    word(1'b0, 8'h0a, -1, 1'b1, 0);
    word(1'b0, 8'h41, -1, 1'b1, 1);
    word(1'b0, 8'h42, -1, 1'b1, 0);
    wr(OFS_PAT, 32'h4200_0000, RESP_OK);
    wr(OFS_CTRL, CTRL_RST | 32'h0040_8002, RESP_OK);
    word(1'b0, 8'h0a, -1, 1'b1, 0);
    word(1'b0, 8'h42, -1, 1'b1, 0);
    word(1'b0, 8'h42, -1, 1'b1, 1);
    report_and_stop;
  end

  // Cuts a hang short well beyond the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
